// [src/cmpe_pkg.sv]
/*
 * Package for the comparator event logic: register offsets, field
 * positions, reset values and the bus carrier type.
 * Assumes a plain single-clock register port, 8-bit registers.
 */
package cmpe_pkg;
    // ========================================================
    // Register offsets
    localparam logic [2:0] OFS_CTRL0  = 3'h0;
    localparam logic [2:0] OFS_CTRL1  = 3'h1;
    localparam logic [2:0] OFS_RESULT = 3'h2;
    localparam logic [2:0] OFS_FLAG   = 3'h3;
    localparam logic [2:0] OFS_ENA    = 3'h4;
    localparam logic [2:0] OFS_IRQC   = 3'h5;
    localparam logic [2:0] OFS_ISTAT  = 3'h6;
    localparam logic [2:0] OFS_IMASK  = 3'h7;
    // ========================================================
    // Field positions
    localparam int POS_INV      = 5;
    localparam int POS_SEL_HI   = 4;
    localparam int POS_SEL_LO   = 3;
    localparam int POS_FLAG0    = 5;
    localparam int POS_FLAG1    = 6;
    localparam int POS_PER_EN   = 6;
    localparam int POS_GLB_EN   = 7;
    // ========================================================
    // Reset values
    localparam logic [7:0] RST_CTRL  = 8'h00;
    localparam logic [7:0] RST_FLAG  = 8'h00;
    localparam logic [7:0] RST_ENA   = 8'h00;
    localparam logic [7:0] RST_IRQC  = 8'h00;
    localparam logic [7:0] RST_ISTAT = 8'h00;
    localparam logic [7:0] RST_IMASK = 8'h00;
    // ========================================================
    // Event selection codes
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_RISE = 2'b01,
        SEL_FALL = 2'b10,
        SEL_ANY  = 2'b11
    } cmpe_sel_t;
    // Register access carrier
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cmpe_bus_t;
endpackage

// [src/cmpe_chan.sv]
/*
 * One comparator channel: synchroniser, polarity, edge selection.
 * Assumes raw comparator input is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module cmpe_chan (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       cmp_raw,
    input  wire logic       invert,
    input  wire logic [1:0] select,
    output logic            result,
    output logic            event_hit
);
    import cmpe_pkg::*;
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic adj;
    logic rise;
    logic fall;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= cmp_raw;
            sync2_r <= sync1_r;
        end
    end

    assign adj = sync2_r ^ invert;

    // Previous adjusted value and registered result
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= 1'b0;
            result <= 1'b0;
        end else begin
            prev_r <= adj;
            result <= adj;
        end
    end

    assign rise = adj & ~prev_r;
    assign fall = ~adj & prev_r;

    always_comb begin
        case (cmpe_sel_t'(select))
            SEL_RISE: event_hit = rise;
            SEL_FALL: event_hit = fall;
            SEL_ANY:  event_hit = rise | fall;
            default:  event_hit = 1'b0;
        endcase
    end

    AST_SEL_NONE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (select == 2'b00) |-> !event_hit)
        else $error("event fired with selection none");
endmodule

// [src/cmpe_top.sv]
/*
 * Comparator event and interrupt logic for two comparators.
 * Assumes raw comparator outputs are asynchronous; register port
 * is a single-cycle strobe bus on clk_sys with read data next cycle.
 */
`timescale 1ns/1ps
module cmpe_top (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic [1:0]         cmp_raw,
    input  wire cmpe_pkg::cmpe_bus_t bus,
    output logic [7:0]              rdata,
    output logic [1:0]              comparator_result_out,
    output logic                    cpu_irq,
    output logic                    irq
);
    import cmpe_pkg::*;

    // ========================================================
    // Registers
    logic [7:0] ctrl_r [2];
    logic [7:0] flag_r;
    logic [7:0] ena_r;
    logic [7:0] irqc_r;
    logic [1:0] istat_r;
    logic [1:0] imask_r;
    logic [1:0] result;
    logic [1:0] hit;
    logic [1:0] flag_bits;
    logic [1:0] ena_bits;
    logic [1:0] wr_flag;
    logic       wr_flag_en;
    logic       rd_istat;

    // ========================================================
    // Channels
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            cmpe_chan u_chan (
                .clk_sys   (clk_sys),
                .reset_n   (reset_n),
                .cmp_raw   (cmp_raw[g]),
                .invert    (ctrl_r[g][POS_INV]),
                .select    (ctrl_r[g][POS_SEL_HI:POS_SEL_LO]),
                .result    (result[g]),
                .event_hit (hit[g])
            );
        end
    endgenerate

    assign comparator_result_out = result;

    // ========================================================
    // Control registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r[0] <= RST_CTRL;
            ctrl_r[1] <= RST_CTRL;
        end else if (bus.wr && bus.addr == OFS_CTRL0) begin
            ctrl_r[0] <= bus.wdata;
        end else if (bus.wr && bus.addr == OFS_CTRL1) begin
            ctrl_r[1] <= bus.wdata;
        end
    end

    // Enable registers and interrupt mask
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ena_r   <= RST_ENA;
            irqc_r  <= RST_IRQC;
            imask_r <= RST_IMASK[1:0];
        end else if (bus.wr) begin
            if (bus.addr == OFS_ENA)
                ena_r <= bus.wdata;
            if (bus.addr == OFS_IRQC)
                irqc_r <= bus.wdata;
            if (bus.addr == OFS_IMASK)
                imask_r <= bus.wdata[1:0];
        end
    end

    // ========================================================
    // Event flags
    assign wr_flag_en = bus.wr && bus.addr == OFS_FLAG;
    assign wr_flag    = {bus.wdata[POS_FLAG1], bus.wdata[POS_FLAG0]};
    assign flag_bits  = {flag_r[POS_FLAG1], flag_r[POS_FLAG0]};

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flag_r <= RST_FLAG;
        end else begin
            if (wr_flag_en) begin
                flag_r <= bus.wdata;
                flag_r[POS_FLAG0] <= wr_flag[0] | hit[0];
                flag_r[POS_FLAG1] <= wr_flag[1] | hit[1];
            end else begin
                flag_r[POS_FLAG0] <= flag_r[POS_FLAG0] | hit[0];
                flag_r[POS_FLAG1] <= flag_r[POS_FLAG1] | hit[1];
            end
        end
    end

    assign ena_bits = {ena_r[POS_FLAG1], ena_r[POS_FLAG0]};
    assign cpu_irq  = |(flag_bits & ena_bits) & irqc_r[POS_PER_EN] & irqc_r[POS_GLB_EN];

    // ========================================================
    // Block interrupt status, cleared by read
    assign rd_istat = bus.rd && bus.addr == OFS_ISTAT;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            istat_r <= RST_ISTAT[1:0];
        else if (rd_istat)
            istat_r <= hit;
        else
            istat_r <= istat_r | hit;
    end

    assign irq = |(istat_r & imask_r);

    // ========================================================
    // Read data, one cycle after strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                OFS_CTRL0:  rdata <= ctrl_r[0];
                OFS_CTRL1:  rdata <= ctrl_r[1];
                OFS_RESULT: rdata <= {6'h00, result};
                OFS_FLAG:   rdata <= flag_r;
                OFS_ENA:    rdata <= ena_r;
                OFS_IRQC:   rdata <= irqc_r;
                OFS_ISTAT:  rdata <= {6'h00, istat_r};
                OFS_IMASK:  rdata <= {6'h00, imask_r};
                default:    rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    // ========================================================
    // Assertions
    AST_FLAG_STICKY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $past(flag_r[POS_FLAG0]) && !$past(wr_flag_en) |-> flag_r[POS_FLAG0])
        else $error("flag dropped without software write");
    AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        hit[1] |=> flag_r[POS_FLAG1])
        else $error("event did not set flag");
    AST_SW_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_flag_en && bus.wdata[POS_FLAG0] |=> flag_r[POS_FLAG0])
        else $error("software set of flag failed");
    AST_IRQ_GATE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cpu_irq |-> irqc_r[POS_GLB_EN] && irqc_r[POS_PER_EN] && |(flag_bits & ena_bits))
        else $error("interrupt without all enables");
    AST_RESULT_PIN: assert property (@(posedge clk_sys) disable iff (!reset_n)
        bus.rd && bus.addr == OFS_RESULT |=> rdata[1:0] == $past(comparator_result_out))
        else $error("result register differs from pin");
    AST_RESULT_RO: assert property (@(posedge clk_sys) disable iff (!reset_n)
        bus.rd && bus.addr == OFS_RESULT |=> rdata[7:2] == 6'h00)
        else $error("result register upper bits not zero");

    // ========================================================
    // Named steps used by the event and register checks
    sequence s_sel0_rise;
        ctrl_r[0][POS_SEL_HI:POS_SEL_LO] == SEL_RISE;
    endsequence
    sequence s_sel0_fall;
        ctrl_r[0][POS_SEL_HI:POS_SEL_LO] == SEL_FALL;
    endsequence
    sequence s_sel0_any;
        ctrl_r[0][POS_SEL_HI:POS_SEL_LO] == SEL_ANY;
    endsequence
    sequence s_sel0_none;
        ctrl_r[0][POS_SEL_HI:POS_SEL_LO] == SEL_NONE;
    endsequence
    sequence s_sel1_rise;
        ctrl_r[1][POS_SEL_HI:POS_SEL_LO] == SEL_RISE;
    endsequence
    sequence s_sel1_fall;
        ctrl_r[1][POS_SEL_HI:POS_SEL_LO] == SEL_FALL;
    endsequence
    sequence s_sel1_any;
        ctrl_r[1][POS_SEL_HI:POS_SEL_LO] == SEL_ANY;
    endsequence
    sequence s_sel1_none;
        ctrl_r[1][POS_SEL_HI:POS_SEL_LO] == SEL_NONE;
    endsequence
    sequence s_flag_write;
        wr_flag_en;
    endsequence
    sequence s_result_write;
        bus.wr && bus.addr == OFS_RESULT;
    endsequence
    sequence s_istat_read;
        rd_istat;
    endsequence
    sequence s_flag_read;
        bus.rd && bus.addr == OFS_FLAG;
    endsequence

    AST_RISE0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_sel0_rise ##1 $rose(result[0]) |-> flag_r[POS_FLAG0])
        else $error("rising edge did not flag channel 0");

    AST_FALL0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_sel0_fall ##1 $fell(result[0]) |-> flag_r[POS_FLAG0])
        else $error("falling edge did not flag channel 0");

    AST_ANY0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_sel0_any ##1 $changed(result[0]) |-> flag_r[POS_FLAG0])
        else $error("change did not flag channel 0");

    AST_NONE0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_sel0_none ##1 ($changed(result[0]) && !$past(flag_r[POS_FLAG0]) && !$past(wr_flag_en))
        |-> !flag_r[POS_FLAG0])
        else $error("selection none flagged channel 0");

    AST_RISE1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_sel1_rise ##1 $rose(result[1]) |-> flag_r[POS_FLAG1])
        else $error("rising edge did not flag channel 1");

    AST_FALL1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_sel1_fall ##1 $fell(result[1]) |-> flag_r[POS_FLAG1])
        else $error("falling edge did not flag channel 1");

    AST_ANY1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_sel1_any ##1 $changed(result[1]) |-> flag_r[POS_FLAG1])
        else $error("change did not flag channel 1");

    AST_NONE1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_sel1_none ##1 ($changed(result[1]) && !$past(flag_r[POS_FLAG1]) && !$past(wr_flag_en))
        |-> !flag_r[POS_FLAG1])
        else $error("selection none flagged channel 1");

    AST_FLAG0_SET: assert property (@(posedge clk_sys) disable iff (!reset_n)
        hit[0] |=> flag_r[POS_FLAG0])
        else $error("event did not set flag 0");

    AST_FLAG1_STICKY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        flag_r[POS_FLAG1] && !wr_flag_en |=> flag_r[POS_FLAG1])
        else $error("flag 1 dropped without software write");

    AST_SW_SET1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_flag_write ##0 bus.wdata[POS_FLAG1] |=> flag_r[POS_FLAG1])
        else $error("software set of flag 1 failed");

    AST_SW_CLEAR0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_flag_write ##0 (!bus.wdata[POS_FLAG0] && !hit[0]) |=> !flag_r[POS_FLAG0])
        else $error("software clear of flag 0 failed");

    AST_SW_CLEAR1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_flag_write ##0 (!bus.wdata[POS_FLAG1] && !hit[1]) |=> !flag_r[POS_FLAG1])
        else $error("software clear of flag 1 failed");

    AST_NO_SPONT0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !flag_r[POS_FLAG0] && !wr_flag_en && !hit[0] |=> !flag_r[POS_FLAG0])
        else $error("flag 0 set without cause");

    AST_NO_SPONT1: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !flag_r[POS_FLAG1] && !wr_flag_en && !hit[1] |=> !flag_r[POS_FLAG1])
        else $error("flag 1 set without cause");

    AST_IRQ_ON: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (|(flag_bits & ena_bits)) && irqc_r[POS_PER_EN] && irqc_r[POS_GLB_EN] |-> cpu_irq)
        else $error("interrupt missing with all enables set");

    AST_IRQ_NO_GLB: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !irqc_r[POS_GLB_EN] |-> !cpu_irq)
        else $error("interrupt with global enable clear");

    AST_IRQ_NO_PER: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !irqc_r[POS_PER_EN] |-> !cpu_irq)
        else $error("interrupt with peripheral enable clear");

    AST_IRQ_NO_LOCAL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (flag_bits & ena_bits) == 2'b00 |-> !cpu_irq)
        else $error("interrupt without enabled flag");

    AST_CTRL0_WR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        bus.wr && bus.addr == OFS_CTRL0 |=> ctrl_r[0] == $past(bus.wdata))
        else $error("control 0 write lost");

    AST_CTRL1_WR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        bus.wr && bus.addr == OFS_CTRL1 |=> ctrl_r[1] == $past(bus.wdata))
        else $error("control 1 write lost");

    AST_RESULT_WR_IGNORED: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_result_write |=> $stable(ctrl_r[0]) && $stable(ctrl_r[1]) && $stable(ena_r) && $stable(irqc_r)
        && $stable(imask_r))
        else $error("write to result register changed state");

    AST_RD_IDLE_ZERO: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !bus.rd |=> rdata == 8'h00)
        else $error("read data not zero without read");

    AST_FLAG_READ: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_flag_read |=> rdata == $past(flag_r))
        else $error("flag register read differs");

    AST_ISTAT_SET0: assert property (@(posedge clk_sys) disable iff (!reset_n)
        hit[0] |=> istat_r[0])
        else $error("event did not set block status");

    AST_ISTAT_CLR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_istat_read ##0 (hit == 2'b00) |=> istat_r == 2'b00)
        else $error("status read did not clear");

    AST_IRQ_MASKED: assert property (@(posedge clk_sys) disable iff (!reset_n)
        imask_r == 2'b00 |-> !irq)
        else $error("block interrupt with all masked");
endmodule

// [verification/cmpe_cmp_model.sv]
/*
 * Behavioural pair of analog comparators feeding the raw outputs.
 * Assumes the bench sets the wanted levels; no tie to clk_sys.
 */
`timescale 1ns/1ps
module cmpe_cmp_model #(
    parameter int SKEW_NS = 17
) (
    input  wire logic [1:0] level,
    output logic      [1:0] cmp_raw
);
    // Lag the outputs by SKEW_NS so edges land away from the clock edges
    initial cmp_raw = 2'h0;
    always @(level) begin
        cmp_raw <= #(SKEW_NS) level;
    end
endmodule

// [verification/cmpe_top_bench.sv]
/*
 * Self-checking bench for the comparator event logic.
 * Assumes the package, the design and the comparator model compile first.
 */
`timescale 1ns/1ps
module cmpe_top_bench;
    import cmpe_pkg::*;
    logic       clk_sys = 1'b0;
    logic       reset_n = 1'b0;
    logic [1:0] level   = 2'h0;
    logic [1:0] cmp_raw;
    cmpe_bus_t  bus     = '0;
    logic [7:0] rdata;
    logic [1:0] comparator_result_out;
    logic       cpu_irq;
    logic       irq;
    logic [7:0] d;
    int         n_errors = 0;
    int         n_tests  = 0;

    // ========================================================
    // Clock, comparator model and design
    always #25 clk_sys = ~clk_sys;
    cmpe_cmp_model u_cmp (.level(level), .cmp_raw(cmp_raw));
    cmpe_top uut (.clk_sys(clk_sys), .reset_n(reset_n), .cmp_raw(cmp_raw), .bus(bus), .rdata(rdata),
                  .comparator_result_out(comparator_result_out), .cpu_irq(cpu_irq), .irq(irq));

    // ========================================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge clk_sys);
        bus.wr    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk_sys);
        bus.rd   <= 1'b0;
        #1 v = rdata;
    endtask
    // Covers the two synchroniser stages plus margin for the skew
    task automatic settle;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask

    // ========================================================
    // Reset values and writes to read-only places
    task automatic reset_regs;
        logic [2:0] a [6] = '{OFS_CTRL0, OFS_CTRL1, OFS_FLAG, OFS_ENA, OFS_IRQC, OFS_IMASK};
        logic [7:0] e [6] = '{RST_CTRL, RST_CTRL, RST_FLAG, RST_ENA, RST_IRQC, RST_IMASK};
        foreach (a[i]) begin
            rd(a[i], d);
            check(d, e[i]);
        end
        wr(OFS_RESULT, 8'hff);
        rd(OFS_RESULT, d);
        check(d, 8'h00);
        wr(OFS_ISTAT, 8'hff);
        rd(OFS_ISTAT, d);
        check(d, RST_ISTAT);
    endtask

    // ========================================================
    // Every channel, polarity and selection against both edges
    task automatic edge_table;
        logic [7:0] ctl;
        logic [2:0] ca;
        logic       er;
        logic       ef;
        wr(OFS_IMASK, 8'h03);
        for (int c = 0; c < 2; c++) begin
            for (int p = 0; p < 2; p++) begin
                for (int s = 0; s < 4; s++) begin
                    ca  = (c == 0) ? OFS_CTRL0 : OFS_CTRL1;
                    ctl = 8'(p << POS_INV);
                    er  = (s == SEL_ANY) || (s == (p ? SEL_FALL : SEL_RISE));
                    ef  = (s == SEL_ANY) || (s == (p ? SEL_RISE : SEL_FALL));
                    wr(ca, ctl);
                    settle();
                    check({7'h0, comparator_result_out[c]}, 8'(p));
                    wr(ca, ctl | 8'(s << POS_SEL_LO));
                    wr(OFS_FLAG, 8'h00);
                    rd(OFS_ISTAT, d);
                    level[c] <= 1'b1;
                    settle();
                    rd(OFS_RESULT, d);
                    check({7'h0, d[c]}, 8'(!p));
                    check({7'h0, comparator_result_out[c]}, 8'(!p));
                    rd(OFS_FLAG, d);
                    check(d, 8'(er) << (POS_FLAG0 + c));
                    check({7'h0, irq}, 8'(er));
                    rd(OFS_ISTAT, d);
                    check(d, 8'(er) << c);
                    wr(OFS_FLAG, 8'h00);
                    level[c] <= 1'b0;
                    settle();
                    rd(OFS_FLAG, d);
                    check(d, 8'(ef) << (POS_FLAG0 + c));
                    rd(OFS_ISTAT, d);
                    check({7'h0, irq}, 8'h00);
                end
            end
        end
    endtask

    // ========================================================
    // Software set, sticky flags and the enable gating
    task automatic enables;
        wr(OFS_IMASK, 8'h00);
        wr(OFS_FLAG, 8'h60);
        rd(OFS_FLAG, d);
        check(d, 8'h60);
        for (int k = 0; k < 8; k++) begin
            wr(OFS_ENA, k[0] ? 8'h60 : 8'h00);
            wr(OFS_IRQC, {k[2], k[1], 6'h0});
            #1;
            check({7'h0, cpu_irq}, {7'h0, k == 7});
        end
        wr(OFS_FLAG, 8'h00);
        wr(OFS_ENA, 8'h00);
        wr(OFS_IRQC, 8'h00);
        level <= 2'h1;
        settle();
        rd(OFS_FLAG, d);
        check(d, 8'h20);
        check({7'h0, cpu_irq}, 8'h00);
        check({7'h0, irq}, 8'h00);
        wr(OFS_CTRL0, 8'h00);
        level <= 2'h0;
        settle();
        rd(OFS_FLAG, d);
        check(d, 8'h20);
        wr(OFS_FLAG, 8'h00);
        rd(OFS_FLAG, d);
        check(d, 8'h00);
    endtask

    // ========================================================
    // Verdict and end of run
    task automatic complete_run;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        reset_regs();
        edge_table();
        enables();
        complete_run();
    end
endmodule
